// [rtl/packet_spacing_checker.sv]
// Purpose: Device-side tracking of bank state, write buffer and packet spacing
// Assumes: Packets arrive already decoded, one column and one row per cycle at most
// Notes: Spacing faults are reported as one-cycle error flags, never dropped silently
// How it works
// - Close variants count as no-op, store, fetch and also schedule a close.
// - An implied close acts as a row close under all close checks.
// - Any permitting column packet retires the buffer; bank comes from buffer.
// - Refresh open and close follow open and close spacing.
// - Neighbours share amplifiers except across the 15/16 boundary.
// - Autoclose fetch closes a fixed offset after its packet; autoclose store a fixed offset after its retire.
// - Retire comes with a later store, or with a column packet one retire interval after a store unless fetched.
`timescale 1ns/1ps
module packet_spacing_checker #(
   parameter logic [7:0] PACKET_LEN = spacing_pkg::PACKET_LENGTH_CYC,
   parameter logic [7:0] COL_CYCLE = spacing_pkg::COLUMN_CYCLE_CYC,
   parameter logic [7:0] FETCH_LAT = spacing_pkg::FETCH_DATA_LATENCY_CYC,
   parameter logic [7:0] STORE_LAT = spacing_pkg::STORE_DATA_LATENCY_CYC,
   parameter logic [7:0] RETIRE_INT = spacing_pkg::STORE_RETIRE_INTERVAL_CYC,
   parameter logic [7:0] FETCH_CLOSE = spacing_pkg::FETCH_TO_CLOSE_INTERVAL_CYC,
   parameter logic [7:0] RETIRE_CLOSE = spacing_pkg::RETIRE_TO_CLOSE_INTERVAL_CYC,
   parameter logic [7:0] OPEN_CLOSE = spacing_pkg::OPEN_TO_CLOSE_MIN_CYC,
   parameter logic [7:0] CLOSE_REC = spacing_pkg::CLOSE_RECOVERY_MIN_CYC,
   parameter logic [7:0] OPEN_OPEN = spacing_pkg::OPEN_TO_OPEN_SAME_BANK_CYC,
   parameter int unsigned AC_OFFSET = spacing_pkg::AUTOCLOSE_OFFSET_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // This device's identity
   input wire logic [4:0] my_dev_in,
   // Column command packet
   input wire logic col_valid_in,
   input wire spacing_pkg::col_op_t col_op_in,
   input wire logic [4:0] col_dev_in,
   input wire logic [4:0] col_bank_in,
   // Column extension packet close
   input wire logic ext_close_in,
   input wire logic [4:0] ext_dev_in,
   input wire logic [4:0] ext_bank_in,
   // Row packet
   input wire logic row_valid_in,
   input wire spacing_pkg::row_op_t row_op_in,
   input wire logic [4:0] row_dev_in,
   input wire logic [4:0] row_bank_in,
   // Device state and events
   output logic [31:0] bank_open_out,
   output logic retire_out,
   output logic [4:0] retire_bank_out,
   output logic close_out,
   output logic [4:0] close_bank_out,
   output logic error_out,
   output logic [6:0] error_flags_out
);
   import spacing_pkg::*;
   logic [31:0] bank_open_r;
   logic [7:0] open_age_r [BANKS];
   logic [7:0] close_age_r [BANKS];
   logic [7:0] col_age_r, row_age_r, fetch_age_r, retire_age_r, wb_age_r;
   logic [4:0] fetch_bank_r, wb_bank_r, last_retire_bank_r;
   logic wb_close_r, prev_fetch_me_r, prev_store_me_r, pend_prev_r, rtr_arm_r;
   spacing_pkg::wbuf_state_t wb_state_r;

   // Column decode; close variants fold onto plain ops
   wire col_me = col_valid_in && (col_dev_in == my_dev_in);
   wire col_is_fetch = (col_op_in == COL_FETCH) || (col_op_in == COL_FETCH_AC);
   wire col_is_store = (col_op_in == COL_STORE) || (col_op_in == COL_STORE_AC);
   wire fetch_me = col_me && col_is_fetch;
   wire store_me = col_me && col_is_store;
   wire wb_held = (wb_state_r == WB_HELD);
   // A later store or an aged packet retires; a fetch to us holds it back
   wire retire_now = col_valid_in && wb_held &&
                     (store_me || ((wb_age_r >= RETIRE_INT) && !fetch_me));

   // Required column gap
   wire [7:0] gap_turn = COL_CYCLE + FETCH_LAT - STORE_LAT;
   wire [7:0] col_req = (fetch_me && rtr_arm_r) ? RETIRE_INT :
                        (col_valid_in && col_is_store && prev_fetch_me_r) ? gap_turn :
                        COL_CYCLE;
   wire col_gap_err = col_valid_in && (col_age_r < col_req);

   // Close scheduling from column side
   wire direct_close = col_me && ((col_op_in == COL_CLOSE) || (col_op_in == COL_FETCH_AC));
   wire ext_me = ext_close_in && (ext_dev_in == my_dev_in);
   wire retire_close = retire_now && wb_close_r;
   wire sched_v = direct_close || ext_me || retire_close;
   wire [4:0] sched_bank = direct_close ? col_bank_in : ext_me ? ext_bank_in : wb_bank_r;
   wire sched_multi = (direct_close && ext_me) || (direct_close && retire_close) ||
                      (ext_me && retire_close);
   wire ac_v;
   wire [4:0] ac_bank;

   close_delay_line #(.DEPTH(AC_OFFSET)) u_close_line (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .sched_valid_in(sched_v),
      .sched_bank_in(sched_bank),
      .due_valid_out(ac_v),
      .due_bank_out(ac_bank)
   );

   // Row decode; refresh maps to open and close
   wire row_act = row_valid_in && (row_op_in != ROW_NOOP);
   wire row_me = row_act && (row_dev_in == my_dev_in);
   wire pin_open = row_me && ((row_op_in == ROW_OPEN) || (row_op_in == ROW_REF_OPEN));
   wire pin_close = row_me && ((row_op_in == ROW_CLOSE) || (row_op_in == ROW_REF_CLOSE));
   wire eff_close = pin_close || ac_v;
   wire [4:0] eff_bank = pin_close ? row_bank_in : ac_bank;
   wire sched_clash = sched_multi || (pin_close && ac_v);
   wire row_gap_err = row_act && (row_age_r < PACKET_LEN);

   // Region scans over all banks
   logic [31:0] close_region, open_region, open_hit;
   logic open_young, close_young;
   always_comb begin
      open_young = 1'b0;
      close_young = 1'b0;
      for (int i = 0; i < BANKS; i++) begin
         close_region[i] = eff_close && near(5'(i), eff_bank);
         open_region[i] = near(5'(i), row_bank_in);
         open_hit[i] = pin_open && (5'(i) == row_bank_in);
         if (open_region[i] && ((close_age_r[i] < CLOSE_REC) ||
                                (open_age_r[i] < OPEN_OPEN))) begin
            open_young = 1'b1;
         end
         if (close_region[i] && bank_open_r[i] && (open_age_r[i] < OPEN_CLOSE)) begin
            close_young = 1'b1;
         end
      end
   end

   // Error classification
   wire open_conflict = pin_open && |(bank_open_r & open_region);
   wire open_timing = pin_open && open_young;
   wire close_timing = eff_close && (close_young ||
                       ((fetch_age_r < FETCH_CLOSE) && near(fetch_bank_r, eff_bank)) ||
                       ((retire_age_r < RETIRE_CLOSE) && near(last_retire_bank_r, eff_bank)));
   wire retire_hazard = eff_close && wb_held && near(wb_bank_r, eff_bank);
   wire [6:0] err_nxt = {sched_clash, retire_hazard, close_timing, open_timing,
                         open_conflict, row_gap_err, col_gap_err};
   wire [31:0] bank_open_nxt = (bank_open_r & ~close_region) | open_hit;

   // Per-bank open and close ages; one on the cycle after the event, like the column ages
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < BANKS; i++) begin
            open_age_r[i] <= AGE_RESET;
            close_age_r[i] <= AGE_RESET;
         end
      end else begin
         for (int i = 0; i < BANKS; i++) begin
            open_age_r[i] <= open_hit[i] ? 8'h01 : sat_inc(open_age_r[i]);
            close_age_r[i] <= close_region[i] ? 8'h01 : sat_inc(close_age_r[i]);
         end
      end
   end

   // Column history and write buffer
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         col_age_r <= AGE_RESET;
         fetch_age_r <= AGE_RESET;
         retire_age_r <= AGE_RESET;
         wb_age_r <= AGE_RESET;
         fetch_bank_r <= 5'h00;
         last_retire_bank_r <= 5'h00;
         wb_bank_r <= 5'h00;
         wb_close_r <= 1'b0;
         wb_state_r <= WB_EMPTY;
         prev_fetch_me_r <= 1'b0;
         prev_store_me_r <= 1'b0;
         pend_prev_r <= 1'b0;
         rtr_arm_r <= 1'b0;
      end else begin
         col_age_r <= col_valid_in ? 8'h01 : sat_inc(col_age_r);
         fetch_age_r <= fetch_me ? 8'h01 : sat_inc(fetch_age_r);
         retire_age_r <= retire_now ? 8'h01 : sat_inc(retire_age_r);
         wb_age_r <= store_me ? 8'h01 : sat_inc(wb_age_r);
         if (fetch_me) begin
            fetch_bank_r <= col_bank_in;
         end
         if (retire_now) begin
            last_retire_bank_r <= wb_bank_r;
         end
         if (store_me) begin
            wb_state_r <= WB_HELD;
            wb_bank_r <= col_bank_in;
            wb_close_r <= (col_op_in == COL_STORE_AC);
         end else if (retire_now) begin
            wb_state_r <= WB_EMPTY;
         end
         if (col_valid_in) begin
            // Arm the retire gap only for store after store or fetch-with-pending
            rtr_arm_r <= store_me && (prev_store_me_r || (prev_fetch_me_r && pend_prev_r));
            prev_fetch_me_r <= fetch_me;
            prev_store_me_r <= store_me;
            pend_prev_r <= wb_held;
         end
      end
   end

   // Row history and registered outputs
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         row_age_r <= AGE_RESET;
         bank_open_r <= BANK_OPEN_RESET;
         retire_out <= 1'b0;
         retire_bank_out <= 5'h00;
         close_out <= 1'b0;
         close_bank_out <= 5'h00;
         error_out <= 1'b0;
         error_flags_out <= 7'h00;
      end else begin
         row_age_r <= row_act ? 8'h01 : sat_inc(row_age_r);
         bank_open_r <= bank_open_nxt;
         retire_out <= retire_now;
         retire_bank_out <= wb_bank_r;
         close_out <= eff_close;
         close_bank_out <= eff_bank;
         error_out <= |err_nxt;
         error_flags_out <= err_nxt;
      end
   end

   assign bank_open_out = bank_open_r;

   // Checks on the device's own tracking
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   property p_close_clears;
      close_out |-> !bank_open_r[close_bank_out];
   endproperty
   a_close_clears: assert property (p_close_clears) else $error("closed bank still open");
   property p_open_sets;
      pin_open && !eff_close |=> bank_open_r[$past(row_bank_in)];
   endproperty
   a_open_sets: assert property (p_open_sets) else $error("opened bank not marked");
   property p_autoclose_offset;
      direct_close && !sched_multi |-> ##5 (close_out && close_bank_out == $past(col_bank_in, 5));
   endproperty
   a_autoclose_offset: assert property (p_autoclose_offset) else $error("implied close late");
   property p_fetch_blocks_retire;
      fetch_me && wb_held |=> !retire_out && wb_held;
   endproperty
   a_fetch_blocks_retire: assert property (p_fetch_blocks_retire) else $error("retire on fetch");
   property p_store_loads;
      store_me |=> wb_held && (wb_bank_r == $past(col_bank_in));
   endproperty
   a_store_loads: assert property (p_store_loads) else $error("store not buffered");
   property p_col_gap;
      col_valid_in && (col_age_r < COL_CYCLE) |=> error_out && error_flags_out[ERR_COL_GAP];
   endproperty
   a_col_gap: assert property (p_col_gap) else $error("short column gap missed");
   property p_open_conflict;
      pin_open && bank_open_r[row_bank_in] |=> error_flags_out[ERR_OPEN_CONFLICT];
   endproperty
   a_open_conflict: assert property (p_open_conflict) else $error("reopen not flagged");
   property p_row_gap;
      row_act ##1 row_act |=> error_flags_out[ERR_ROW_GAP];
   endproperty
   a_row_gap: assert property (p_row_gap) else $error("row gap not flagged");
   property p_hazard;
      eff_close && wb_held && (wb_bank_r == eff_bank) |=> error_flags_out[ERR_RETIRE_HAZARD];
   endproperty
   a_hazard: assert property (p_hazard) else $error("unretired close not flagged");

   c_retire: cover property (store_me ##[1:10] retire_now);
   c_autoclose: cover property (direct_close ##[1:8] close_out);
   c_turnaround: cover property (fetch_me ##[1:6] store_me);
   c_open_close: cover property (pin_open ##[1:20] pin_close);
endmodule : packet_spacing_checker

// [rtl/spacing_pkg.sv]
// Purpose: Shared constants, types and helpers for the packet spacing checker
// Assumes: One interface clock of 125 MHz; times are least times, rounded up
// Notes: Cycle counts derive from the nanosecond figures and the clock period
package spacing_pkg;
   localparam int unsigned BANKS = 32;
   localparam int unsigned BANK_W = 5;
   localparam int unsigned DEV_W = 5;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned CLK_PERIOD_PS = 8000;

   // Spacing times in ns, plain defaults
   localparam int unsigned PACKET_LENGTH_NS = 10;
   localparam int unsigned COLUMN_CYCLE_NS = 10;
   localparam int unsigned FETCH_DATA_LATENCY_NS = 20;
   localparam int unsigned STORE_DATA_LATENCY_NS = 10;
   localparam int unsigned STORE_RETIRE_INTERVAL_NS = 20;
   localparam int unsigned FETCH_TO_CLOSE_INTERVAL_NS = 10;
   localparam int unsigned RETIRE_TO_CLOSE_INTERVAL_NS = 10;
   localparam int unsigned OPEN_TO_CLOSE_MIN_NS = 40;
   localparam int unsigned CLOSE_RECOVERY_MIN_NS = 20;
   localparam int unsigned OPEN_TO_OPEN_SAME_BANK_NS = 60;
   localparam int unsigned AUTOCLOSE_OFFSET_NS = 30;

   // Least times round up to whole cycles
   localparam logic [7:0] PACKET_LENGTH_CYC =
      8'((PACKET_LENGTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] COLUMN_CYCLE_CYC =
      8'((COLUMN_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] FETCH_DATA_LATENCY_CYC =
      8'((FETCH_DATA_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] STORE_DATA_LATENCY_CYC =
      8'((STORE_DATA_LATENCY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] STORE_RETIRE_INTERVAL_CYC =
      8'((STORE_RETIRE_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] FETCH_TO_CLOSE_INTERVAL_CYC =
      8'((FETCH_TO_CLOSE_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] RETIRE_TO_CLOSE_INTERVAL_CYC =
      8'((RETIRE_TO_CLOSE_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] OPEN_TO_CLOSE_MIN_CYC =
      8'((OPEN_TO_CLOSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] CLOSE_RECOVERY_MIN_CYC =
      8'((CLOSE_RECOVERY_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0] OPEN_TO_OPEN_SAME_BANK_CYC =
      8'((OPEN_TO_OPEN_SAME_BANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam int unsigned AUTOCLOSE_OFFSET_CYC =
      (AUTOCLOSE_OFFSET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Values after reset
   localparam logic [7:0] AGE_RESET = 8'hFF;
   localparam logic [31:0] BANK_OPEN_RESET = 32'h0000_0000;
   // Lower bank of the one neighbour pair that shares no sense amplifier
   localparam logic [4:0] UNSHARED_LO = 5'h0F;

   // Error flag positions
   localparam int unsigned ERR_COL_GAP = 0;
   localparam int unsigned ERR_ROW_GAP = 1;
   localparam int unsigned ERR_OPEN_CONFLICT = 2;
   localparam int unsigned ERR_OPEN_TIMING = 3;
   localparam int unsigned ERR_CLOSE_TIMING = 4;
   localparam int unsigned ERR_RETIRE_HAZARD = 5;
   localparam int unsigned ERR_SCHED_CLASH = 6;
   localparam int unsigned ERR_W = 7;

   typedef enum logic [2:0] {
      COL_NOOP = 3'h0, COL_FETCH = 3'h1, COL_STORE = 3'h2,
      COL_CLOSE = 3'h3, COL_STORE_AC = 3'h4, COL_FETCH_AC = 3'h5
   } col_op_t;

   typedef enum logic [2:0] {
      ROW_NOOP = 3'h0, ROW_OPEN = 3'h1, ROW_CLOSE = 3'h2,
      ROW_REF_OPEN = 3'h3, ROW_REF_CLOSE = 3'h4
   } row_op_t;

   typedef enum logic {WB_EMPTY = 1'b0, WB_HELD = 1'b1} wbuf_state_t;

   // Saturating age counter step
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hFF) ? v : v + 8'h01;
   endfunction : sat_inc

   // Banks sharing a sense amplifier; the 15/16 pair shares none
   function automatic logic adjacent(input logic [4:0] a, input logic [4:0] b);
      logic step;
      step = ({1'b0, a} == {1'b0, b} + 6'h01) || ({1'b0, b} == {1'b0, a} + 6'h01);
      adjacent = step && !((a == UNSHARED_LO) || (b == UNSHARED_LO)) ||
                 step && (a != UNSHARED_LO + 5'h01) && (b != UNSHARED_LO + 5'h01)
                 && !((a == UNSHARED_LO) || (b == UNSHARED_LO)) ||
                 step && !((a == UNSHARED_LO && b == UNSHARED_LO + 5'h01) ||
                           (b == UNSHARED_LO && a == UNSHARED_LO + 5'h01));
   endfunction : adjacent

   // Same bank or a neighbour on the shared amplifier
   function automatic logic near(input logic [4:0] a, input logic [4:0] b);
      near = (a == b) || adjacent(a, b);
   endfunction : near
endpackage : spacing_pkg

// [rtl/close_delay_line.sv]
// Purpose: Fixed-offset delay for implied bank closes from column commands
// Assumes: At most one close is scheduled per cycle
// Notes: Depth is the autoclose offset in cycles, at least one
`timescale 1ns/1ps
module close_delay_line #(
   parameter int unsigned DEPTH = spacing_pkg::AUTOCLOSE_OFFSET_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Scheduled close
   input wire logic sched_valid_in,
   input wire logic [4:0] sched_bank_in,
   // Close due now
   output logic due_valid_out,
   output logic [4:0] due_bank_out
);
   logic [DEPTH-1:0] valid_r;
   logic [4:0] bank_r [DEPTH];

   // Plain shift line; cheap for small offsets and keeps every close in order
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         valid_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            bank_r[i] <= 5'h00;
         end
      end else begin
         valid_r[0] <= sched_valid_in;
         bank_r[0] <= sched_bank_in;
         for (int i = 1; i < DEPTH; i++) begin
            valid_r[i] <= valid_r[i-1];
            bank_r[i] <= bank_r[i-1];
         end
      end
   end

   assign due_valid_out = valid_r[DEPTH-1];
   assign due_bank_out = bank_r[DEPTH-1];
endmodule : close_delay_line

// [verification/pkt_issuer.sv]
// Purpose: Controller model issuing row and column packets on command
// Assumes: Tasks are entered at a falling edge of the clock
// Notes: Fields released by idle carry random values; col and row leave the other channel's fields stale
`timescale 1ns/1ps
module pkt_issuer (
   // Clock
   input wire logic mclk_in,
   // Column packet
   output logic col_valid_out,
   output spacing_pkg::col_op_t col_op_out,
   output logic [4:0] col_dev_out,
   output logic [4:0] col_bank_out,
   // Row packet
   output logic row_valid_out,
   output spacing_pkg::row_op_t row_op_out,
   output logic [4:0] row_dev_out,
   output logic [4:0] row_bank_out
);
   // Release both channels; held fields scrambled for n cycles
   task automatic idle(input int n);
      col_valid_out = 1'b0;
      row_valid_out = 1'b0;
      col_op_out = spacing_pkg::col_op_t'(3'($urandom % 6));
      col_dev_out = 5'($urandom);
      col_bank_out = 5'($urandom);
      row_op_out = spacing_pkg::row_op_t'(3'($urandom % 5));
      row_dev_out = 5'($urandom);
      row_bank_out = 5'($urandom);
      repeat (n) @(negedge mclk_in);
   endtask : idle

   // One column packet; no clear at the end, so back-to-back packets stay legal to drive
   task automatic col(input spacing_pkg::col_op_t op, input logic [4:0] dev,
                      input logic [4:0] bank);
      row_valid_out = 1'b0;
      col_valid_out = 1'b1;
      col_op_out = op;
      col_dev_out = dev;
      col_bank_out = bank;
      @(negedge mclk_in);
   endtask : col

   // One row packet
   task automatic row(input spacing_pkg::row_op_t op, input logic [4:0] dev,
                      input logic [4:0] bank);
      col_valid_out = 1'b0;
      row_valid_out = 1'b1;
      row_op_out = op;
      row_dev_out = dev;
      row_bank_out = bank;
      @(negedge mclk_in);
   endtask : row
endmodule : pkt_issuer

// [verification/tb_packet_spacing_checker.sv]
// Purpose: Self-checking bench for the packet spacing checker
// Assumes: Default spacing counts; this device is number 2
// Notes: Events are noted in a queue and matched in order by a monitor
`timescale 1ns/1ps
module tb_packet_spacing_checker;
   localparam logic [4:0] ME = 5'h02;
   logic mclk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic col_valid, row_valid, retire, close, error;
   spacing_pkg::col_op_t col_op;
   spacing_pkg::row_op_t row_op;
   logic [4:0] col_dev, col_bank, row_dev, row_bank, retire_bank, close_bank, od;
   logic [31:0] bank_open;
   logic ext_close = 1'b0;
   logic [4:0] ext_dev, ext_bank;
   logic [6:0] flags;
   logic [19:0] exp_q[$];
   logic [19:0] exp_v;
   int num_errors = 0;
   int n_checks = 0;

   // 125 MHz clock
   always #4 mclk_in = ~mclk_in;

   pkt_issuer u_ctl (.mclk_in(mclk_in), .col_valid_out(col_valid), .col_op_out(col_op),
      .col_dev_out(col_dev), .col_bank_out(col_bank), .row_valid_out(row_valid),
      .row_op_out(row_op), .row_dev_out(row_dev), .row_bank_out(row_bank));

   // Extension close driven straight from the bench
   packet_spacing_checker u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .my_dev_in(ME),
      .col_valid_in(col_valid), .col_op_in(col_op), .col_dev_in(col_dev),
      .col_bank_in(col_bank), .ext_close_in(ext_close), .ext_dev_in(ext_dev),
      .ext_bank_in(ext_bank),
      .row_valid_in(row_valid), .row_op_in(row_op), .row_dev_in(row_dev),
      .row_bank_in(row_bank), .bank_open_out(bank_open), .retire_out(retire),
      .retire_bank_out(retire_bank), .close_out(close), .close_bank_out(close_bank),
      .error_out(error), .error_flags_out(flags));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   // Expected event: close, its bank, retire, its bank, error flags
   task automatic note(input logic c, input logic [4:0] cb, input logic r,
                       input logic [4:0] rb, input logic [6:0] f);
      exp_q.push_back({c, cb, r, rb, |f, f});
   endtask : note

   task automatic complete_run;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // Any event pulse pops the oldest note; banks masked when their strobe is low
   always @(negedge mclk_in) begin
      if (resetn_in && (close || retire || error)) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 20'h00000;
         check("event", {12'h000, close, close ? close_bank : 5'h00, retire,
               retire ? retire_bank : 5'h00, error, flags}, {12'h000, exp_v});
      end
   end

   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #(8 * 3000);
      num_errors++;
      complete_run();
   end

   initial begin
      void'($urandom(83812));
      ext_dev = 5'($urandom);
      ext_bank = 5'($urandom);
      u_ctl.idle(0);
      od = 5'h03 + 5'($urandom % 28);
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in);
      resetn_in = 1'b1;
      // Legal open and close, then a close too early
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h03);
      check("open map", bank_open, 32'h0000_0008);
      u_ctl.idle(4);
      note(1'b1, 5'h03, 1'b0, 5'h00, 7'h00);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h03);
      u_ctl.idle(10);
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h03);
      u_ctl.idle(1);
      note(1'b1, 5'h03, 1'b0, 5'h00, 7'h10);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h03);
      u_ctl.idle(1);
      // Refresh open inside recovery and row cycle, refresh close legal
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h08);
      u_ctl.row(spacing_pkg::ROW_REF_OPEN, ME, 5'h03);
      u_ctl.idle(10);
      note(1'b1, 5'h03, 1'b0, 5'h00, 7'h00);
      u_ctl.row(spacing_pkg::ROW_REF_CLOSE, ME, 5'h03);
      u_ctl.idle(10);
      // Back-to-back row packets to another device
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h02);
      u_ctl.row(spacing_pkg::ROW_CLOSE, od, 5'h01);
      u_ctl.row(spacing_pkg::ROW_CLOSE, od, 5'h14);
      u_ctl.idle(10);
      // Unshared 15/16 pair, then a neighbour of an open bank
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h0F);
      u_ctl.idle(9);
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h10);
      u_ctl.idle(9);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h04);
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h11);
      check("open map", bank_open, 32'h0003_8000);
      u_ctl.idle(5);
      note(1'b1, 5'h10, 1'b0, 5'h00, 7'h00);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h10);
      u_ctl.idle(2);
      note(1'b1, 5'h0F, 1'b0, 5'h00, 7'h00);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h0F);
      u_ctl.idle(10);
      check("closed map", bank_open, 32'h0000_0000);
      // Column pairs and retire of the write buffer
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h01);
      u_ctl.idle(1);
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h01);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h01);
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h01);
      u_ctl.idle(2);
      note(1'b0, 5'h00, 1'b1, 5'h01, 7'h00);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.idle(1);
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h04);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b1, 5'h04, 7'h00);
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h06);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h01);
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h06);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b1, 5'h06, 7'h00);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.idle(10);
      // Close of a neighbour right after a fetch
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h09);
      u_ctl.idle(5);
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h09);
      note(1'b1, 5'h0A, 1'b0, 5'h00, 7'h10);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h0A);
      u_ctl.idle(10);
      // Autoclose fetch closes at the fixed offset
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h09);
      u_ctl.idle(5);
      note(1'b1, 5'h09, 1'b0, 5'h00, 7'h00);
      u_ctl.col(spacing_pkg::COL_FETCH_AC, ME, 5'h09);
      u_ctl.idle(3);
      check("early close", {31'h0, close}, 32'h0);
      u_ctl.idle(1);
      check("offset close", {31'h0, close}, 32'h1);
      u_ctl.idle(6);
      check("closed map", bank_open, 32'h0000_0000);
      // Reopen, close over an unretired store, then a close right after the retire
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h14);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h0C);
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h14);
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h14);
      note(1'b1, 5'h14, 1'b0, 5'h00, 7'h30);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h14);
      u_ctl.idle(2);
      note(1'b0, 5'h00, 1'b1, 5'h14, 7'h00);
      note(1'b1, 5'h13, 1'b0, 5'h00, 7'h10);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h13);
      u_ctl.idle(2);
      // Fetch with a store pending, store, fetch; then back-to-back column packets
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h01);
      u_ctl.idle(1);
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h01);
      u_ctl.idle(2);
      note(1'b0, 5'h00, 1'b1, 5'h01, 7'h00);
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h02);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h01);
      u_ctl.col(spacing_pkg::COL_FETCH, ME, 5'h02);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b1, 5'h02, 7'h00);
      note(1'b0, 5'h00, 1'b0, 5'h00, 7'h01);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.idle(1);
      // Store then fetch elsewhere; no-op then a distant close with no gap
      u_ctl.col(spacing_pkg::COL_STORE, ME, 5'h03);
      u_ctl.idle(1);
      u_ctl.col(spacing_pkg::COL_FETCH, od, 5'h03);
      u_ctl.idle(1);
      note(1'b0, 5'h00, 1'b1, 5'h03, 7'h00);
      note(1'b1, 5'h1A, 1'b0, 5'h00, 7'h00);
      u_ctl.col(spacing_pkg::COL_NOOP, od, 5'h00);
      u_ctl.row(spacing_pkg::ROW_CLOSE, ME, 5'h1A);
      u_ctl.idle(5);
      // Extension close lands at the fixed offset
      u_ctl.row(spacing_pkg::ROW_OPEN, ME, 5'h18);
      u_ctl.idle(5);
      note(1'b1, 5'h18, 1'b0, 5'h00, 7'h00);
      ext_close = 1'b1;
      ext_dev = ME;
      ext_bank = 5'h18;
      @(negedge mclk_in);
      ext_close = 1'b0;
      u_ctl.idle(6);
      check("ext closed map", bank_open, 32'h0000_0000);
      check("pending", 32'(exp_q.size()), 32'h0);
      complete_run();
   end
endmodule : tb_packet_spacing_checker
